/* cfg_host.sv */
// Host model shifting configuration words into the shared pins
`timescale 1ns/1ns
module cfg_host (
  input wire logic clk_i,
  output logic [2:0] pins_o
);
  // Pins: port select low, serial clock, serial data
  initial pins_o = 3'h4;
  // Send n bits MSB first, clock parked at its idle level
  task automatic send(input logic [11:0] w, input logic inv, input int n);
    for (int i = 11; i > 11 - n; i--) begin
      @(posedge clk_i) pins_o <= {1'b0, inv, w[i]};
      repeat (2) @(posedge clk_i);
      pins_o[1] <= ~inv;
      repeat (2) @(posedge clk_i);
      pins_o[1] <= inv;
    end
    @(posedge clk_i) pins_o <= {1'b1, inv, ~w[12-n]};
  endtask
endmodule

/* cfg_shift.sv */
// Serial configuration shifter sampled on the system clock
`timescale 1ns/1ns
module cfg_shift
  import pinmux_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic accept_i,
  input wire logic sdata_i,
  input wire logic sclk_i,
  input wire logic invert_i,
  output shift_state_t state_o,
  output logic word_done_o
);
  logic sclk_prev_q; // Last sampled serial clock
  logic act_edge; // Active serial clock edge
  shift_state_t st_q; // Shift register and count

  // Active edge: rising normally, falling when inverted
  assign act_edge = invert_i ? (sclk_prev_q & ~sclk_i) : (~sclk_prev_q & sclk_i);
  assign state_o = st_q;
  assign word_done_o = act_edge & accept_i & (st_q.count == CNT_LAST);

  // Serial clock history
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_prev_q <= 1'b0;
    end else if (en_i) begin
      sclk_prev_q <= sclk_i;
    end
  end

  // MSB-first shift, only while selected
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else if (en_i) begin
      if (!accept_i) begin
        st_q.count <= '0;
      end else if (act_edge) begin
        st_q.word <= {st_q.word[CFG_W-2:0], sdata_i};
        st_q.count <= (st_q.count == CNT_LAST) ? '0 : st_q.count + 4'h1;
      end
    end
  end
endmodule

/* dual_function_config_pins.sv */
// Top: shared pins as parallel data bits or serial configuration port, APB registers
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// - Modes 0-2: pins drive bits 14, 15
// - Modes 0-2: pins drive bits 16, 17
// - Mode 3, source low: serial register config
// - Source high: config from hardware pins
// - Clock invert picks capture edge
// - Port accepts only while selected
module dual_function_config_pins
  import pinmux_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CLK_EN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [3:0] SHARED_PIN_I,
  output logic [3:0] SHARED_PIN_O,
  output logic [3:0] SHARED_PIN_OE_O,
  input wire logic [3:0] PARALLEL_DATA_HI_I,
  input wire logic [CFG_W-1:0] HW_CONFIG_I,
  output logic [CFG_W-1:0] ACTIVE_CONFIG_O,
  output logic CONFIG_SOURCE_SELECT_O
);
  logic [2:0] ctrl_q; // Mode and clock-invert control
  logic [1:0] mode; // Interface mode field
  logic serial_mode; // Mode 3 selected
  logic sw_cfg; // Serial software configuration active
  logic [CFG_W-1:0] sw_cfg_q; // Serial configuration register
  logic [3:0] pdata_q; // Registered parallel bits 14 to 17
  logic [CFG_W-1:0] active_q; // Registered applied configuration
  cfg_pins_t pins; // Shared pins in serial role
  shift_state_t sh; // Shifter state
  logic word_done; // Full word captured
  logic wr_en; // APB write strobe
  logic rd_hit; // Address is mapped

  assign mode = ctrl_q[CTRL_MODE_LSB +: MODE_W];
  assign serial_mode = (mode == MODE_SERIAL);
  assign pins.source_select = SHARED_PIN_I[PIN_B14];
  assign pins.serial_in = SHARED_PIN_I[PIN_B15];
  assign pins.serial_clock = SHARED_PIN_I[PIN_B16];
  assign pins.port_select = SHARED_PIN_I[PIN_B17];
  // Software path only in mode 3 with source select low
  assign sw_cfg = serial_mode & ~pins.source_select;

  // Shifter sees a deasserted select outside software mode
  cfg_shift u_shift (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESET_N_I),
    .en_i(CLK_EN_I),
    .accept_i(sw_cfg & ~pins.port_select),
    .sdata_i(pins.serial_in),
    .sclk_i(pins.serial_clock),
    .invert_i(ctrl_q[CTRL_INV_BIT]),
    .state_o(sh),
    .word_done_o(word_done)
  );

  // Pin direction: outputs in parallel modes, inputs in serial mode
  assign SHARED_PIN_OE_O = serial_mode ? 4'h0 : 4'hf;
  assign SHARED_PIN_O = pdata_q;
  assign CONFIG_SOURCE_SELECT_O = serial_mode & pins.source_select;
  assign ACTIVE_CONFIG_O = active_q;

  // APB: zero wait states, never errors
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = 1'b0;
  assign rd_hit = (PADDR_I == ADDR_CTRL) | (PADDR_I == ADDR_HWCFG) | (PADDR_I == ADDR_ACTIVE)
    | (PADDR_I == ADDR_SHIFT) | (PADDR_I == ADDR_PDATA);

  // Control register writes
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_q <= CTRL_RST;
    end else if (CLK_EN_I && wr_en && PADDR_I == ADDR_CTRL) begin
      ctrl_q <= PWDATA_I[2:0];
    end
  end

  // Parallel data bits 14 to 17, sampled each cycle with CLK_EN_I high
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pdata_q <= 4'h0;
    end else if (CLK_EN_I) begin
      pdata_q[PIN_B14] <= PARALLEL_DATA_HI_I[0];
      pdata_q[PIN_B15] <= PARALLEL_DATA_HI_I[1];
      pdata_q[PIN_B16] <= PARALLEL_DATA_HI_I[2];
      pdata_q[PIN_B17] <= PARALLEL_DATA_HI_I[3];
    end
  end

  // Latch a completed serial word
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sw_cfg_q <= CFG_RST;
    end else if (CLK_EN_I && word_done) begin
      sw_cfg_q <= {sh.word[CFG_W-2:0], pins.serial_in};
    end
  end

  // Applied configuration source select
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      active_q <= CFG_RST;
    end else if (CLK_EN_I) begin
      if (sw_cfg) begin
        active_q <= sw_cfg_q;
      end else begin
        active_q <= HW_CONFIG_I;
      end
    end
  end

  // Read mux
  always_comb begin
    PRDATA_O = 32'h0;
    if (rd_hit) begin
      unique case (PADDR_I)
        ADDR_CTRL: PRDATA_O = {29'h0, ctrl_q};
        ADDR_HWCFG: PRDATA_O = {20'h0, sw_cfg_q};
        ADDR_ACTIVE: PRDATA_O = {19'h0, sw_cfg, active_q};
        ADDR_SHIFT: PRDATA_O = {16'h0, sh};
        ADDR_PDATA: PRDATA_O = {28'h0, pdata_q};
        default: PRDATA_O = 32'h0;
      endcase
    end
  end
endmodule

/* pinmux_chk.sv */
// Checker for the shared pin multiplexer
`timescale 1ns/1ns
module pinmux_chk
  import pinmux_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic CLK_EN_I,
  input wire logic [3:0] SHARED_PIN_I,
  input wire logic [3:0] SHARED_PIN_O,
  input wire logic [3:0] SHARED_PIN_OE_O,
  input wire logic [3:0] PARALLEL_DATA_HI_I,
  input wire logic [CFG_W-1:0] HW_CONFIG_I,
  input wire logic [CFG_W-1:0] ACTIVE_CONFIG_O,
  input wire logic CONFIG_SOURCE_SELECT_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Serial software mode running
  wire sw = CLK_EN_I && SHARED_PIN_OE_O == 4'h0 && !SHARED_PIN_I[0];
  sequence port_idle;
    (sw && SHARED_PIN_I[3]) [*4];
  endsequence
  sequence clock_still;
    (sw && $stable(SHARED_PIN_I[2])) [*5];
  endsequence
  a_low_pair_data: assert property (CLK_EN_I && SHARED_PIN_OE_O[1:0] == 2'h3 |=>
    SHARED_PIN_O[1:0] == $past(PARALLEL_DATA_HI_I[1:0])) else $error("bits 14-15 wrong");
  a_high_pair_data: assert property (CLK_EN_I && SHARED_PIN_OE_O[3:2] == 2'h3 |=>
    SHARED_PIN_O[3:2] == $past(PARALLEL_DATA_HI_I[3:2])) else $error("bits 16-17 wrong");
  a_source_flag: assert property (CONFIG_SOURCE_SELECT_O ==
    (SHARED_PIN_OE_O == 4'h0 && SHARED_PIN_I[0])) else $error("source flag wrong");
  a_hw_follow: assert property (CLK_EN_I && CONFIG_SOURCE_SELECT_O |=>
    ACTIVE_CONFIG_O == $past(HW_CONFIG_I)) else $error("pin config not applied");
  a_idle_hold: assert property (port_idle |=> $stable(ACTIVE_CONFIG_O))
    else $error("config moved while deselected");
  a_edge_only: assert property (clock_still |=> $stable(ACTIVE_CONFIG_O))
    else $error("config moved without clock edge");
  a_no_sw_parallel: assert property (SHARED_PIN_OE_O == 4'hf |-> !CONFIG_SOURCE_SELECT_O)
    else $error("serial source in parallel mode");
endmodule
bind dual_function_config_pins pinmux_chk u_pinmux_chk (.*);

/* pinmux_pkg.sv */
// Package: constants and carriers for the shared configuration pin multiplexer
package pinmux_pkg;
  // Interface mode field
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_SERIAL = 2'h3;
  // Serial configuration register width and reset value
  localparam int CFG_W = 12;
  localparam logic [11:0] CFG_RST = 12'h000;
  // Bit count width for a configuration word
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_LAST = 4'hb;
  // Shared pin positions on the parallel bus
  localparam int PIN_B14 = 0;
  localparam int PIN_B15 = 1;
  localparam int PIN_B16 = 2;
  localparam int PIN_B17 = 3;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HWCFG = 8'h04;
  localparam logic [7:0] ADDR_ACTIVE = 8'h08;
  localparam logic [7:0] ADDR_SHIFT = 8'h0c;
  localparam logic [7:0] ADDR_PDATA = 8'h10;
  // Control register field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INV_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Serial port pins as seen by the device
  typedef struct packed {
    logic source_select;
    logic serial_in;
    logic serial_clock;
    logic port_select;
  } cfg_pins_t;
  // Serial port status
  typedef struct packed {
    logic [CFG_W-1:0] word;
    logic [CNT_W-1:0] count;
  } shift_state_t;
endpackage

/* test_dual_function_config_pins.sv */
// Self-checking bench for the shared pin multiplexer
`timescale 1ns/1ns
module test_dual_function_config_pins
  import pinmux_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, look = 0, src = 1, sel, rdy, err;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, got, ex, q[$];
  logic [3:0] pd = 4'h0, po, poe, pin;
  logic [11:0] hw = 12'h000, act, w;
  logic [2:0] hp;
  int fails = 0, tests_run = 0, cyc = 0;
  always #10 clk = ~clk;
  // Wire level from both parties
  assign pin = (poe & po) | (~poe & {hp, src});
  dual_function_config_pins u_dual_function_config_pins (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(rdy), .PSLVERR_O(err), .SHARED_PIN_I(pin), .SHARED_PIN_O(po), .SHARED_PIN_OE_O(poe),
    .PARALLEL_DATA_HI_I(pd), .HW_CONFIG_I(hw), .ACTIVE_CONFIG_O(act), .CONFIG_SOURCE_SELECT_O(sel));
  cfg_host u_cfg_host (.clk_i(clk), .pins_o(hp));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Compare each read or pin look with the oldest note
  always @(posedge clk) begin
    cyc++;
    if (psel && pen && rdy && !pwr || look) begin
      got = look ? {23'h0, sel, poe, poe & po} : prd;
      ex = q.pop_front();
      tests_run++;
      if (got !== ex) begin
        fails++;
        $display("mismatch at %0t got %h expected %h", $time, got, ex);
      end
    end
    // Every completed access must end without an error response
    if (psel && pen && rdy) begin
      tests_run++;
      if (err !== 1'b0) begin
        fails++;
        $display("mismatch at %0t got %h expected %h", $time, err, 1'b0);
      end
    end
    if (cyc > 20000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (!rdy);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic peek(input logic [31:0] e);
    q.push_back(e);
    @(posedge clk);
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'h40e43641));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, 32'h0);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, ADDR_CTRL, 32'(m));
      pd <= 4'($urandom);
      repeat (2) @(posedge clk);
      peek({24'h0, 4'hf, pd});
    end
    hw <= 12'($urandom);
    apb(1'b1, ADDR_CTRL, 32'h3);
    peek({23'h0, 1'b1, 8'h00});
    u_cfg_host.send(12'($urandom), 1'b0, 12);
    rd(ADDR_ACTIVE, {20'h0, hw});
    src <= 1'b0;
    w = 12'($urandom);
    u_cfg_host.send(w, 1'b0, 12);
    rd(ADDR_HWCFG, {20'h0, w});
    rd(ADDR_ACTIVE, {19'h0, 1'b1, w});
    apb(1'b1, ADDR_CTRL, 32'h4);
    apb(1'b1, ADDR_CTRL, 32'h7);
    w = 12'($urandom);
    u_cfg_host.send(w, 1'b1, 12);
    rd(ADDR_ACTIVE, {19'h0, 1'b1, w});
    u_cfg_host.send(12'($urandom), 1'b1, 7);
    w = 12'($urandom);
    u_cfg_host.send(w, 1'b1, 12);
    rd(ADDR_ACTIVE, {19'h0, 1'b1, w});
    rd(8'h14, 32'h0);
    print_verdict();
  end
endmodule
